// ---- core/ebm_pkg.sv ----
// Shared constants and types for the external bus master and its far end
package ebm_pkg;

  // ****************************************
  // Widths of the bus
  // ****************************************
  localparam int ADDR_W = 34;
  localparam int DATA_W = 32;
  localparam int LANE_W = 4;
  localparam int BLOCK_WORDS = 4;

  // ****************************************
  // Beat counts, words and lane values
  // ****************************************
  localparam logic [2:0] BEATS_SINGLE = 3'h1;
  localparam logic [2:0] BEATS_BURST = 3'h4;
  localparam logic [2:0] BEATS_NONE = 3'h0;
  localparam logic [1:0] WORD_FIRST = 2'h0;
  localparam logic [1:0] WORD_LAST = 2'h3;
  localparam logic [3:0] LANES_ALL = 4'hF;
  localparam logic [3:0] MASK_FULL = 4'hF;

  // ****************************************
  // Read sampling delays after first address accept
  // ****************************************
  localparam logic [1:0] RD_DLY_SINGLE = 2'h0;
  localparam logic [1:0] RD_DLY_BURST = 2'h1;

  // ****************************************
  // Read return FIFO
  // ****************************************
  localparam int FIFO_W = 33;
  localparam int FIFO_D = 32;
  localparam int FIFO_LVL_W = 6;
  localparam logic [5:0] FIFO_ROOM_MAX = 6'h1C;

  // ****************************************
  // Far end queue and memory
  // ****************************************
  localparam int EXT_QD = 4;
  localparam int EXT_QE_W = 9;
  localparam logic [2:0] EXT_Q_HIGH = 3'h2;
  localparam int EXT_MEM_WORDS = 16;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [33:0] RST_ADDR = 34'h0_0000_0000;

  // ****************************************
  // Sequencer states, one bit changes from IDLE to RUN and from RUN to DONE
  // ****************************************
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01,
    ST_DONE = 2'b11
  } ebm_state_e;

endpackage

// ---- core/ebm_if.sv ----
// Bus carrier joining the bus master and the external system logic
`timescale 1ns/100ps
interface ebm_if;
  logic [35:2] word_addr_bus;
  logic [3:0] lane_enables;
  logic addr_accept;
  logic fetch_flag;
  logic addr_valid_flag;
  logic write_flag;
  logic [31:0] read_word_bus;
  logic read_word_valid;
  logic read_fault;
  logic [31:0] write_word_bus;
  logic write_word_accept;
  logic write_fault;
  logic subblock_order_select;
  logic burst_flag;
  logic burst_head;
  logic burst_tail;

  modport dev (
    output word_addr_bus, lane_enables, fetch_flag, addr_valid_flag,
    output write_flag, write_word_bus, burst_flag, burst_head, burst_tail,
    input addr_accept, read_word_bus, read_word_valid, read_fault,
    input write_word_accept, write_fault, subblock_order_select
  );

  modport ext (
    input word_addr_bus, lane_enables, fetch_flag, addr_valid_flag,
    input write_flag, write_word_bus, burst_flag, burst_head, burst_tail,
    output addr_accept, read_word_bus, read_word_valid, read_fault,
    output write_word_accept, write_fault, subblock_order_select
  );
endinterface

// ---- core/ebm_master.sv ----
// Bus master end: read return FIFO and the transaction sequencer
//
// Contract
// - Word address and lane enables every transaction
// - Far end throttles addresses with addr_accept
// - Drive address early, hold past accept edge
// - Single read fetch_flag only uncached fetch
// - addr_valid_flag whenever address is valid
// - write_flag low reads, high writes
// - Single read sampled from one clock after
// - Read fault comes with read_word_valid
// - Single write data held until accepted
// - Write fault one clock after write accept
// - Burst read: four words, aligned block
// - Sequential order steps upward with wrap
// - Sub-block order XORs start with step
// - Burst read fetch_flag for instruction fetch
// - burst_flag while burst address on bus
// - burst_head first address, burst_tail last
// - Burst read sampled from two clocks after
// - Burst write only for full block
// - Burst write starts at word zero
// - Burst write keeps write, burst, valid flags
// - Burst write word held, next after accept
// - Burst write fault one clock after accept
`timescale 1ns/100ps

// ****************************************
// Read return FIFO
// ****************************************
module ebm_fifo import ebm_pkg::*; #(
  parameter int W = FIFO_W,
  parameter int D = FIFO_D
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data,
  // Occupancy including the output stage
  output logic [$clog2(D+1)-1:0] level
);
  localparam int PW = $clog2(D);
  localparam int CW = $clog2(D+1);
  logic [W-1:0] mem [D];
  logic [PW-1:0] wp;
  logic [PW-1:0] rp;
  logic [CW-1:0] cnt;
  logic push;
  logic pop;

  // Output stage refills whenever empty or drained this cycle
  assign in_ready = (cnt != CW'(D));
  assign push = in_valid && in_ready;
  assign pop = (cnt != '0) && (!out_valid || out_ready);
  assign level = cnt + CW'(out_valid);

  // Storage writes
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wp] <= in_data;
    end
  end

  // Pointers and count
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wp <= '0;
      rp <= '0;
      cnt <= '0;
    end else begin
      if (push) begin
        wp <= wp + 1'b1;
      end
      if (pop) begin
        rp <= rp + 1'b1;
      end
      cnt <= cnt + CW'(push) - CW'(pop);
    end
  end

  // Registered head word
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      out_valid <= 1'b0;
      out_data <= '0;
    end else if (pop) begin
      out_valid <= 1'b1;
      out_data <= mem[rp];
    end else if (out_ready) begin
      out_valid <= 1'b0;
    end
  end
endmodule

// ****************************************
// Transaction sequencer
// ****************************************
module ebm_master import ebm_pkg::*; (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Bus
  ebm_if.dev bus,
  // Request
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic req_burst,
  input wire logic req_instr,
  input wire logic [35:2] req_addr,
  input wire logic [3:0] req_lanes,
  input wire logic [3:0] req_wmask,
  input wire logic [127:0] req_wdata,
  // Read return
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [31:0] rd_data,
  output logic rd_fault,
  // Completion
  output logic done,
  output logic done_fault
);
  ebm_state_e st;
  logic [35:2] addr;
  logic [3:0] lanes;
  logic avalid, wr_q, instr_q, burst_q, head_q, tail_q;
  logic [1:0] start_w, ab;
  logic [2:0] a_left, d_left;
  logic sblk_q, fault_acc;
  logic [3:0] lanes_q, wmask;
  logic [31:0] wbuf [BLOCK_WORDS];
  logic [31:0] wdata;
  logic [1:0] wsel;
  logic wd_act, wd_burst, wpend;
  logic rarm;
  logic [1:0] rdly;
  logic take, nxt_single, launch, fin, first_acc, rcap, wtake;
  logic l_wr, l_burst;
  logic [1:0] l_word, low;
  logic [2:0] l_beats;
  logic [3:0] src_mask;
  logic [FIFO_LVL_W-1:0] level;
  logic [FIFO_W-1:0] head_word;

  function automatic logic [1:0] low_word(input logic [3:0] m);
    low_word = WORD_FIRST;
    for (int i = 3; i >= 0; i--) begin
      if (m[i]) begin
        low_word = 2'(i);
      end
    end
  endfunction

  // Burst word order: upward wrap or XOR stepping
  function automatic logic [1:0] beat_word(input logic [1:0] s,
                                           input logic [1:0] b,
                                           input logic sb);
    beat_word = sb ? (s ^ b) : (s + b);
  endfunction

  // Bus pins come straight from the sequencer flops
  assign bus.word_addr_bus = addr;
  assign bus.lane_enables = lanes;
  assign bus.addr_valid_flag = avalid;
  assign bus.write_flag = wr_q;
  assign bus.fetch_flag = instr_q;
  assign bus.burst_flag = burst_q;
  assign bus.burst_head = head_q;
  assign bus.burst_tail = tail_q;
  assign bus.write_word_bus = wdata;

  // Launch decode: a new request or the next partial-buffer word
  assign take = (st == ST_IDLE) && req_valid && req_ready;
  assign nxt_single = (st == ST_RUN) && !avalid && (d_left == BEATS_NONE)
                      && !wpend && (wmask != '0);
  assign launch = take || nxt_single;
  assign fin = (st == ST_RUN) && !avalid && (d_left == BEATS_NONE)
               && !wpend && (wmask == '0);
  assign src_mask = take ? req_wmask : wmask;
  assign low = low_word(src_mask);
  assign l_wr = take ? req_write : 1'b1;
  // Only a whole block goes out as a burst write
  assign l_burst = take && (req_write ? (req_wmask == MASK_FULL)
                                      : req_burst);
  assign l_word = l_wr ? (l_burst ? WORD_FIRST : low)
                       : req_addr[3:2];
  assign l_beats = l_burst ? BEATS_BURST : BEATS_SINGLE;
  assign first_acc = avalid && bus.addr_accept && (!burst_q || head_q);
  assign rcap = rarm && (rdly == '0) && bus.read_word_valid;
  assign wtake = wd_act && bus.write_word_accept;

  // Sequencer, handshake and completion report
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= ST_IDLE;
      req_ready <= 1'b0;
      done <= 1'b0;
      done_fault <= 1'b0;
      fault_acc <= 1'b0;
      wmask <= '0;
      sblk_q <= 1'b0;
      lanes_q <= '0;
    end else begin
      done <= 1'b0;
      case (st)
        ST_IDLE: begin
          // Reads are taken only with room for a whole burst
          req_ready <= !take && (level <= FIFO_ROOM_MAX);
          if (take) begin
            st <= ST_RUN;
            fault_acc <= 1'b0;
            sblk_q <= bus.subblock_order_select;
            lanes_q <= req_lanes;
            wmask <= (req_write && !l_burst)
                     ? (req_wmask & ~(4'h1 << low)) : '0;
          end
        end
        ST_RUN: begin
          if ((wpend && bus.write_fault) || (rcap && bus.read_fault)) begin
            fault_acc <= 1'b1;
          end
          if (nxt_single) begin
            wmask <= wmask & ~(4'h1 << low);
          end else if (fin) begin
            st <= ST_DONE;
            done <= 1'b1;
            done_fault <= fault_acc;
          end
        end
        ST_DONE: begin
          st <= ST_IDLE;
        end
        default: begin
          st <= ST_IDLE;
        end
      endcase
    end
  end

  // Address phase: drive early, advance on the edge that takes it
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      addr <= RST_ADDR;
      lanes <= '0;
      avalid <= 1'b0;
      wr_q <= 1'b0;
      instr_q <= 1'b0;
      burst_q <= 1'b0;
      head_q <= 1'b0;
      tail_q <= 1'b0;
      start_w <= WORD_FIRST;
      ab <= WORD_FIRST;
      a_left <= BEATS_NONE;
    end else if (launch) begin
      addr <= {(take ? req_addr[35:4] : addr[35:4]), l_word};
      lanes <= l_burst ? LANES_ALL : (take ? req_lanes : lanes_q);
      avalid <= 1'b1;
      wr_q <= l_wr;
      instr_q <= take && req_instr && !req_write;
      burst_q <= l_burst;
      head_q <= l_burst;
      tail_q <= 1'b0;
      start_w <= l_word;
      ab <= WORD_FIRST;
      a_left <= l_beats;
    end else if (avalid && bus.addr_accept) begin
      if (a_left > BEATS_SINGLE) begin
        ab <= ab + 1'b1;
        addr[3:2] <= beat_word(start_w, ab + 1'b1,
                               sblk_q && !wr_q);
        head_q <= 1'b0;
        tail_q <= (a_left == 3'h2);
        a_left <= a_left - 1'b1;
      end else begin
        avalid <= 1'b0;
        wr_q <= 1'b0;
        instr_q <= 1'b0;
        burst_q <= 1'b0;
        tail_q <= 1'b0;
        a_left <= BEATS_NONE;
      end
    end
  end

  // Write data path, independent of the address phase
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wdata <= RST_WORD;
      wsel <= WORD_FIRST;
      wd_act <= 1'b0;
      wd_burst <= 1'b0;
      wpend <= 1'b0;
      for (int i = 0; i < BLOCK_WORDS; i++) begin
        wbuf[i] <= RST_WORD;
      end
    end else begin
      // Fault arrives one clock after each accepted word
      wpend <= wtake;
      if (take) begin
        for (int i = 0; i < BLOCK_WORDS; i++) begin
          wbuf[i] <= req_wdata[i*32 +: 32];
        end
      end
      if (launch && l_wr) begin
        wd_act <= 1'b1;
        wd_burst <= l_burst;
        wsel <= l_word;
        wdata <= take ? req_wdata[l_word*32 +: 32] : wbuf[l_word];
      end else if (wtake) begin
        if (wd_burst && (wsel != WORD_LAST)) begin
          wsel <= wsel + 1'b1;
          wdata <= wbuf[wsel + 1'b1];
        end else begin
          wd_act <= 1'b0;
        end
      end
    end
  end

  // Read sampling window opens after the first address is taken
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rarm <= 1'b0;
      rdly <= '0;
    end else if (first_acc && !wr_q) begin
      rarm <= 1'b1;
      rdly <= burst_q ? RD_DLY_BURST : RD_DLY_SINGLE;
    end else if (rarm) begin
      if (rdly != '0) begin
        rdly <= rdly - 1'b1;
      end else if (rcap && (d_left == BEATS_SINGLE)) begin
        rarm <= 1'b0;
      end
    end
  end

  // Outstanding data beats of the current transaction
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      d_left <= BEATS_NONE;
    end else if (launch) begin
      d_left <= l_beats;
    end else if (rcap || wtake) begin
      d_left <= d_left - 1'b1;
    end
  end

  // Read data lands in the FIFO; room is checked before issue
  ebm_fifo #(.W(FIFO_W), .D(FIFO_D)) u_rfifo (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .in_valid(rcap),
    .in_ready(),
    .in_data({bus.read_fault, bus.read_word_bus}),
    .out_valid(rd_valid),
    .out_ready(rd_ready),
    .out_data(head_word),
    .level(level)
  );

  assign rd_data = head_word[31:0];
  assign rd_fault = head_word[32];
endmodule

// ---- core/ebm_ext.sv ----
// External system logic end: in-order queue and a small word memory
`timescale 1ns/100ps
module ebm_ext import ebm_pkg::*; (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Bus
  ebm_if.ext bus,
  // Pacing and fault injection
  input wire logic a_stall,
  input wire logic d_stall,
  input wire logic rd_err_inject,
  input wire logic wr_err_inject,
  input wire logic sblk_mode
);
  logic [EXT_QE_W-1:0] q [EXT_QD];
  logic [1:0] qw, qr;
  logic [2:0] q_cnt, next_cnt;
  logic [31:0] mem [EXT_MEM_WORDS];
  logic [EXT_QE_W-1:0] hd;
  logic push, serve, pop;
  logic acc, rvalid, rfault, wacc, wfault, sblk;
  logic [31:0] rdata;

  assign bus.addr_accept = acc;
  assign bus.read_word_valid = rvalid;
  assign bus.read_word_bus = rdata;
  assign bus.read_fault = rfault;
  assign bus.write_word_accept = wacc;
  assign bus.write_fault = wfault;
  assign bus.subblock_order_select = sblk;

  // A fresh entry is never served on its push edge, so a burst
  // read first shows valid where the master first samples
  assign hd = q[qr];
  assign push = bus.addr_valid_flag && acc;
  assign serve = (q_cnt != '0) && !rvalid && !wacc && !d_stall;
  assign pop = (serve && !hd[8]) || wacc;
  assign next_cnt = q_cnt + 3'(push) - 3'(pop);

  // Queue of accepted addresses, in bus order
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      qw <= '0;
      qr <= '0;
      q_cnt <= '0;
      for (int i = 0; i < EXT_QD; i++) begin
        q[i] <= '0;
      end
    end else begin
      if (push) begin
        q[qw] <= {bus.write_flag, bus.lane_enables, bus.word_addr_bus[5:2]};
        qw <= qw + 1'b1;
      end
      if (pop) begin
        qr <= qr + 1'b1;
      end
      q_cnt <= next_cnt;
    end
  end

  // Address throttle keeps one slot spare for the edge in flight
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      acc <= 1'b0;
      sblk <= 1'b0;
    end else begin
      acc <= !a_stall && (next_cnt <= EXT_Q_HIGH);
      sblk <= sblk_mode;
    end
  end

  // Data service: one-cycle pulses, fault aligned per rule
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rvalid <= 1'b0;
      rfault <= 1'b0;
      rdata <= RST_WORD;
      wacc <= 1'b0;
      wfault <= 1'b0;
    end else begin
      rvalid <= serve && !hd[8];
      rfault <= serve && !hd[8] && rd_err_inject;
      wacc <= serve && hd[8];
      wfault <= wacc && wr_err_inject;
      if (serve && !hd[8]) begin
        rdata <= mem[hd[3:0]];
      end
    end
  end

  // Memory with byte lanes
  always_ff @(posedge sys_clk) begin
    if (wacc) begin
      for (int b = 0; b < LANE_W; b++) begin
        if (hd[4+b]) begin
          mem[hd[3:0]][b*8 +: 8] <= bus.write_word_bus[b*8 +: 8];
        end
      end
    end
  end
endmodule

// ---- verif/ebm_chk.sv ----
// Concurrent checks on the bus between the master and the far end
`timescale 1ns/100ps
module ebm_chk (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Address side
  input wire logic [35:2] word_addr_bus,
  input wire logic [3:0] lane_enables,
  input wire logic addr_accept,
  input wire logic fetch_flag,
  input wire logic addr_valid_flag,
  input wire logic write_flag,
  input wire logic subblock_order_select,
  input wire logic burst_flag,
  input wire logic burst_head,
  input wire logic burst_tail,
  // Data side
  input wire logic [31:0] read_word_bus,
  input wire logic read_word_valid,
  input wire logic read_fault,
  input wire logic [31:0] write_word_bus,
  input wire logic write_word_accept,
  input wire logic write_fault
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  // ****************************************
  // Burst beat tracking
  // ****************************************
  logic addr_taken;
  logic [1:0] burst_start;
  logic [1:0] beat_idx;
  logic [35:4] burst_block;
  logic [1:0] next_word;
  assign addr_taken = addr_valid_flag && addr_accept;
  // Sub-block order is an XOR walk, sequential a wrapping add
  assign next_word = subblock_order_select ? (burst_start ^ beat_idx)
                                           : (burst_start + beat_idx);

  // Beat index wraps to zero once the tail beat is taken
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      burst_start <= 2'h0;
      beat_idx <= 2'h0;
      burst_block <= '0;
    end else if (addr_taken && burst_head) begin
      burst_start <= word_addr_bus[3:2];
      burst_block <= word_addr_bus[35:4];
      beat_idx <= 2'h1;
    end else if (addr_taken && burst_flag) begin
      beat_idx <= beat_idx + 2'h1;
    end
  end

  // ****************************************
  // Sequences
  // ****************************************
  sequence s_beat_held;
    addr_valid_flag && !addr_accept;
  endsequence
  sequence s_same_beat;
    addr_valid_flag && $stable(word_addr_bus) && $stable(lane_enables)
      && $stable(write_flag) && $stable(burst_flag);
  endsequence
  sequence s_wburst_start;
    addr_valid_flag && burst_head && write_flag;
  endsequence

  // ****************************************
  // Assertions
  // ****************************************
  a_addr_hold: assert property (s_beat_held |=> s_same_beat)
    else $error("address dropped before accept");
  a_lanes_present: assert property (addr_valid_flag
    |-> lane_enables != 4'h0)
    else $error("no lane enabled on a valid address");
  a_fetch_on_read: assert property (fetch_flag
    |-> addr_valid_flag && !write_flag)
    else $error("fetch flag outside a read address");
  a_burst_order: assert property (addr_valid_flag
    && burst_flag && !burst_head
    |-> word_addr_bus[3:2] == next_word && word_addr_bus[35:4] == burst_block)
    else $error("burst word out of order or block");
  a_head_first: assert property (burst_head
    |-> addr_valid_flag && burst_flag && beat_idx == 2'h0)
    else $error("burst head not on first beat");
  a_tail_fourth: assert property (addr_valid_flag && burst_tail
    |-> burst_flag && beat_idx == 2'h3)
    else $error("burst tail not on fourth beat");
  a_wburst_zero: assert property (s_wburst_start
    |-> word_addr_bus[3:2] == 2'h0)
    else $error("write burst not starting at word zero");
  a_wburst_flags: assert property (s_wburst_start |->
    (addr_valid_flag && write_flag && burst_flag)
    until_with (burst_tail && addr_accept))
    else $error("write burst flags dropped mid burst");
  a_wburst_ends: assert property ((s_wburst_start and addr_accept)
    |-> ##[1:400] (burst_tail && addr_taken))
    else $error("write burst tail never taken");
  a_wdata_hold: assert property (addr_valid_flag && write_flag
    && !write_word_accept |=> $stable(write_word_bus))
    else $error("write data changed before accept");
  a_rfault_pair: assert property (read_fault |-> read_word_valid)
    else $error("read fault without read valid");
  a_wfault_gap: assert property (write_fault
    |-> $past(write_word_accept))
    else $error("write fault not one clock after accept");
endmodule

// ---- verif/cpu_external_bus_master_tb.sv ----
// Testbench: both ends joined, driven through request and read ports
`timescale 1ns/100ps
module cpu_external_bus_master_tb import ebm_pkg::*;;
  localparam int LIMIT = 20000;
  logic sys_clk = 1'b0;
  logic rst_b, req_valid, req_write, req_burst, req_instr, rd_ready;
  logic a_stall, d_stall, rd_err_inject, wr_err_inject, sblk_mode;
  logic stall_en;
  logic [35:2] req_addr;
  logic [3:0] req_lanes, req_wmask;
  logic [127:0] req_wdata;
  logic req_ready, rd_valid, rd_fault, done, done_fault;
  logic [31:0] rd_data;
  logic [32:0] rdq [$];
  logic [31:0] exp_mem [16];
  int fails = 0;
  int samples_checked = 0;
  int cyc = 0;

  ebm_if bus_if ();
  ebm_master ebm_master_inst (.sys_clk(sys_clk), .rst_b(rst_b), .bus(bus_if),
    .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write),
    .req_burst(req_burst), .req_instr(req_instr), .req_addr(req_addr),
    .req_lanes(req_lanes), .req_wmask(req_wmask), .req_wdata(req_wdata),
    .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data),
    .rd_fault(rd_fault), .done(done), .done_fault(done_fault));
  ebm_ext ebm_ext_inst (.sys_clk(sys_clk), .rst_b(rst_b), .bus(bus_if),
    .a_stall(a_stall), .d_stall(d_stall), .rd_err_inject(rd_err_inject),
    .wr_err_inject(wr_err_inject), .sblk_mode(sblk_mode));
  ebm_chk ebm_chk_inst (.sys_clk(sys_clk), .rst_b(rst_b),
    .word_addr_bus(bus_if.word_addr_bus), .lane_enables(bus_if.lane_enables),
    .addr_accept(bus_if.addr_accept), .fetch_flag(bus_if.fetch_flag),
    .addr_valid_flag(bus_if.addr_valid_flag), .write_flag(bus_if.write_flag),
    .subblock_order_select(bus_if.subblock_order_select),
    .burst_flag(bus_if.burst_flag), .burst_head(bus_if.burst_head),
    .burst_tail(bus_if.burst_tail), .read_word_bus(bus_if.read_word_bus),
    .read_word_valid(bus_if.read_word_valid), .read_fault(bus_if.read_fault),
    .write_word_bus(bus_if.write_word_bus),
    .write_word_accept(bus_if.write_word_accept),
    .write_fault(bus_if.write_fault));

  // ****************************************
  // Clock, hang guard, read capture, pacing
  // ****************************************
  always #4 sys_clk = ~sys_clk;

  // Words are captured at the edge that pops them from the FIFO
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (rd_valid === 1'b1 && rd_ready === 1'b1)
      rdq.push_back({rd_fault, rd_data});
    if (cyc == LIMIT) begin
      fails++;
      close_out();
    end
  end

  // Irregular stalls on both address and data paths
  always @(negedge sys_clk) begin
    a_stall <= stall_en & cyc[1];
    d_stall <= stall_en & cyc[2] & cyc[0];
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic check(input string what, input logic [32:0] seen,
      input logic [32:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic present(input logic wr, bu, ins, input logic [35:2] a,
      input logic [3:0] m, input logic [127:0] d);
    @(negedge sys_clk);
    req_valid = 1'b1;
    req_write = wr;
    req_burst = bu;
    req_instr = ins;
    req_addr = a;
    req_lanes = 4'hF;
    req_wmask = m;
    req_wdata = d;
  endtask

  // Holds the request until taken, then waits for completion
  task automatic finish_req(output logic flt);
    int n;
    n = 0;
    while (req_ready !== 1'b1 && n < 300) begin
      @(negedge sys_clk);
      n++;
    end
    @(negedge sys_clk);
    req_valid = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 300) begin
      @(negedge sys_clk);
      n++;
    end
    check("request done", 33'(done), 33'h1);
    flt = done_fault;
  endtask

  task automatic issue(input logic wr, bu, ins, input logic [35:2] a,
      input logic [3:0] m, input logic [127:0] d, output logic flt);
    present(wr, bu, ins, a, m, d);
    finish_req(flt);
  endtask

  task automatic pop(output logic [32:0] w);
    int n;
    n = 0;
    while (rdq.size() == 0 && n < 200) begin
      @(negedge sys_clk);
      n++;
    end
    w = (rdq.size() == 0) ? 'x : rdq.pop_front();
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    logic flt;
    logic seen_rdy;
    logic [32:0] w;
    logic [127:0] d;
    {rst_b, req_valid, req_write, req_burst, req_instr, stall_en} = '0;
    {a_stall, d_stall, rd_err_inject, wr_err_inject, sblk_mode} = '0;
    {req_addr, req_lanes, req_wmask, req_wdata} = '0;
    rd_ready = 1'b1;
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    rst_b = 1'b1;
    // Second pass adds wait states on both paths
    for (int p = 0; p < 2; p++) begin
      stall_en = p[0];
      for (int b = 0; b < 2; b++) begin
        for (int k = 0; k < 4; k++)
          d[32*k +: 32] = 32'hB000_0000 + 32'(p*256 + b*16 + k);
        issue(1'b1, 1'b0, 1'b0, 34'(b*4), 4'hF, d, flt);
        check("burst write fault", 33'(flt), 33'h0);
        for (int k = 0; k < 4; k++) exp_mem[b*4+k] = d[32*k +: 32];
      end
      d = {32'h0, 32'hC1A0_0000 + 32'(p), 32'h0, 32'hC0A0_0000 + 32'(p)};
      issue(1'b1, 1'b0, 1'b0, 34'(8), 4'h5, d, flt);
      check("single write fault", 33'(flt), 33'h0);
      exp_mem[8] = d[31:0];
      exp_mem[10] = d[95:64];
      for (int sb = 0; sb < 2; sb++) begin
        for (int s = 0; s < 4; s++) begin
          sblk_mode = sb[0];
          issue(1'b0, 1'b1, p[0], 34'(s + 4), 4'h0, '0, flt);
          for (int k = 0; k < 4; k++) begin
            pop(w);
            check("burst read word", w,
              {1'b0, exp_mem[4 + ((sb == 1) ? (s ^ k) : ((s + k) % 4))]});
          end
        end
      end
      issue(1'b0, 1'b0, 1'b1, 34'(8), 4'h0, '0, flt);
      pop(w);
      check("single read word", w, {1'b0, exp_mem[8]});
      issue(1'b0, 1'b0, 1'b0, 34'(10), 4'h0, '0, flt);
      pop(w);
      check("single read word", w, {1'b0, exp_mem[10]});
    end
    // Faults on a read and on single and burst writes
    rd_err_inject = 1'b1;
    issue(1'b0, 1'b0, 1'b0, 34'(2), 4'h0, '0, flt);
    pop(w);
    check("read fault bit", 33'(w[32]), 33'h1);
    rd_err_inject = 1'b0;
    wr_err_inject = 1'b1;
    issue(1'b1, 1'b0, 1'b0, 34'(12), 4'h1, '0, flt);
    check("single write fault", 33'(flt), 33'h1);
    issue(1'b1, 1'b0, 1'b0, 34'(12), 4'hF, '0, flt);
    check("burst write fault", 33'(flt), 33'h1);
    wr_err_inject = 1'b0;
    // Fill the read FIFO while the reader stalls
    sblk_mode = 1'b0;
    rd_ready = 1'b0;
    for (int i = 0; i < FIFO_D / BLOCK_WORDS; i++)
      issue(1'b0, 1'b1, 1'b0, '0, 4'h0, '0, flt);
    present(1'b0, 1'b1, 1'b0, '0, 4'h0, '0);
    seen_rdy = 1'b0;
    repeat (20) begin
      @(negedge sys_clk);
      if (req_ready === 1'b1) seen_rdy = 1'b1;
    end
    check("ready while full", 33'(seen_rdy), 33'h0);
    rd_ready = 1'b1;
    finish_req(flt);
    for (int k = 0; k < FIFO_D + BLOCK_WORDS; k++) begin
      pop(w);
      check("drained word", w, {1'b0, exp_mem[k % 4]});
    end
    repeat (10) @(negedge sys_clk);
    check("queue empty", 33'(rdq.size()), 33'h0);
    close_out();
  end
endmodule
